/* hdl/pmx_port1_low.v */
// Function selector for port 1 pins 0 to 3 shared with timer channel 0.
// Assumes an APB master on pclk and timer output levels from pclk logic.
`timescale 1ns/1ps
`include "pmx_consts.vh"

module pmx_port1_low (
    input  wire        pclk,                  // System clock, 100 MHz
    input  wire        presetn,               // Async reset, active low
    input  wire        psel,                  // APB select
    input  wire        penable,               // APB access phase
    input  wire        pwrite,                // APB write
    input  wire [7:0]  paddr,                 // APB byte address
    input  wire [31:0] pwdata,                // APB write data
    output wire        pready,                // APB ready
    output wire        pslverr,               // APB error, unmapped address
    output reg  [31:0] prdata,                // APB read data
    input  wire [3:0]  tmr0_capcmp_out,       // Timer output levels, A to D
    input  wire [3:0]  pin_in,                // Pin levels, pins 0 to 3
    output reg  [3:0]  pin_out,               // Pin drive levels
    output reg  [3:0]  pin_oe,                // Pin output enables
    output reg  [3:0]  tmr0_capcmp_pin,       // Capture input levels, A to D
    output reg  [3:0]  tmr0_capcmp_pin_sel,   // Capture source selected
    output reg         ext_timer_clock_a,     // External clock A from pin 2
    output reg         ext_timer_clock_b      // External clock B from pin 3
);

    // ==========================================================
    // Registers
    // Zero reset: every pin starts as an input
    reg  [5:0]  timer0_mode_register_q;       // Mode field and buffer modes
    reg  [7:0]  timer0_io_control_high_q;     // B and A I/O control
    reg  [7:0]  timer0_io_control_low_q;      // D and C I/O control
    reg  [7:0]  timer0_control_register_q;    // Clear select and prescaler
    reg  [6:0]  psc12_q;                      // Channel 1/2 prescalers, phase count
    reg  [3:0]  dir_q;                        // Direction bits
    reg  [3:0]  data_q;                       // Port data bits
    reg         ack_q;                        // Read data is loaded

    // ==========================================================
    // Decoded fields
    // Slices of the configuration words, then pin, clock and bus signals
    wire [3:0]  timer_mode_field;             // Channel 0 mode
    wire        buffer_mode_a;                // Buffer operation A
    wire        buffer_mode_b;                // Buffer operation B
    wire [3:0]  io_control_a_field;           // A I/O control
    wire [3:0]  io_control_b_field;           // B I/O control
    wire [3:0]  io_control_c_field;           // C I/O control
    wire [3:0]  io_control_d_field;           // D I/O control
    wire [2:0]  counter_clear_select;         // Channel 0 clear source
    wire [2:0]  prescaler_select0;            // Channel 0 prescaler
    wire [2:0]  prescaler_select1;            // Channel 1 prescaler
    wire [2:0]  prescaler_select2;            // Channel 2 prescaler
    wire        phase_count1;                 // Channel 1 phase counting
    wire [3:0]  tmr_sel;                      // Timer owns each pin
    wire [3:0]  cap_sel;                      // Capture source per pin
    wire        clk_a_en;                     // Pin 2 feeds clock A
    wire        clk_b_en;                     // Pin 3 feeds clock B
    wire [3:0]  pin_sync;                     // Filtered pin levels
    wire [3:0]  pin_state;                    // Readback port view
    wire        wr_en;                        // Write commits this edge
    wire        addr_ok;                      // Address is mapped
    reg  [31:0] rd_d;                         // Next read data

    // Mode word: mode, buffer A, buffer B
    // Control word: prescaler, counter clear
    // Word at 0x10: two prescalers, phase count
    assign timer_mode_field     = timer0_mode_register_q[3:0];
    assign buffer_mode_a        = timer0_mode_register_q[`PMX_MODE_BFA_BIT];
    assign buffer_mode_b        = timer0_mode_register_q[`PMX_MODE_BFB_BIT];
    assign io_control_a_field   = timer0_io_control_high_q[3:0];
    assign io_control_b_field   = timer0_io_control_high_q[7:4];
    assign io_control_c_field   = timer0_io_control_low_q[3:0];
    assign io_control_d_field   = timer0_io_control_low_q[7:4];
    assign prescaler_select0    = timer0_control_register_q[2:0];
    assign counter_clear_select = timer0_control_register_q[`PMX_CTRL_CCLR_LSB+2:`PMX_CTRL_CCLR_LSB];
    assign prescaler_select1    = psc12_q[2:0];
    assign prescaler_select2    = psc12_q[`PMX_PSC12_CH2_LSB+2:`PMX_PSC12_CH2_LSB];
    assign phase_count1         = psc12_q[`PMX_PSC12_PHC_BIT];

    // ==========================================================
    // Pin function decoders, one per pin
    // Pins 1 and 3 have no PWM mode 1 output
    // Only pin 2 heeds the buffer modes
    // Each pin has its own blocking clear code
    pmx_pin_fn #(
        .PWM1_OK    (1'b1),
        .BUF_GATE   (1'b0),
        .CCLR_BLOCK (`PMX_CCLR_PIN0)
    ) u_fn0 (
        .mode        (timer_mode_field),
        .ioc         (io_control_a_field),
        .cclr        (counter_clear_select),
        .buf_on      (1'b0),
        .tmr_out_sel (tmr_sel[0]),
        .cap_sel     (cap_sel[0])
    );

    pmx_pin_fn #(
        .PWM1_OK    (1'b0),
        .BUF_GATE   (1'b0),
        .CCLR_BLOCK (`PMX_CCLR_PIN1)
    ) u_fn1 (
        .mode        (timer_mode_field),
        .ioc         (io_control_b_field),
        .cclr        (counter_clear_select),
        .buf_on      (1'b0),
        .tmr_out_sel (tmr_sel[1]),
        .cap_sel     (cap_sel[1])
    );

    pmx_pin_fn #(
        .PWM1_OK    (1'b1),
        .BUF_GATE   (1'b1),
        .CCLR_BLOCK (`PMX_CCLR_PIN2)
    ) u_fn2 (
        .mode        (timer_mode_field),
        .ioc         (io_control_c_field),
        .cclr        (counter_clear_select),
        .buf_on      (buffer_mode_a | buffer_mode_b),
        .tmr_out_sel (tmr_sel[2]),
        .cap_sel     (cap_sel[2])
    );

    pmx_pin_fn #(
        .PWM1_OK    (1'b0),
        .BUF_GATE   (1'b0),
        .CCLR_BLOCK (`PMX_CCLR_PIN3)
    ) u_fn3 (
        .mode        (timer_mode_field),
        .ioc         (io_control_d_field),
        .cclr        (counter_clear_select),
        .buf_on      (1'b0),
        .tmr_out_sel (tmr_sel[3]),
        .cap_sel     (cap_sel[3])
    );

    // ==========================================================
    // External clock selection from any channel's prescaler
    // Phase counting claims both clock pins
    // Enables stay combinational here
    assign clk_a_en = (prescaler_select0 == `PMX_PSC_EXT_A) ||
                      (prescaler_select1 == `PMX_PSC_EXT_A) ||
                      (prescaler_select2 == `PMX_PSC_EXT_A) ||
                      phase_count1;
    assign clk_b_en = (prescaler_select0 == `PMX_PSC_EXT_B) ||
                      (prescaler_select1 == `PMX_PSC_EXT_B) ||
                      (prescaler_select2 == `PMX_PSC_EXT_B) ||
                      phase_count1;

    // ==========================================================
    // Pin input synchroniser
    // Keeps metastability off capture paths
    // Price: five edges from pin to timer
    pmx_sync3 #(
        .WIDTH (4)
    ) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (pin_in),
        .level_q  (pin_sync)
    );

    // ==========================================================
    // Pin drive; timer output overrides data and direction
    // Registered so pins never glitch
    // Reset leaves every pin undriven
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out <= `PMX_RST_4;
            pin_oe  <= `PMX_RST_4;
        end else begin
            pin_out <= (tmr_sel & tmr0_capcmp_out) | (~tmr_sel & data_q);
            pin_oe  <= tmr_sel | dir_q;
        end
    end

    // ==========================================================
    // Capture and clock inputs, sampled from the filtered pin
    // Unselected lines sit low: no stray edge
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tmr0_capcmp_pin     <= `PMX_RST_4;
            tmr0_capcmp_pin_sel <= `PMX_RST_4;
            ext_timer_clock_a   <= 1'b0;
            ext_timer_clock_b   <= 1'b0;
        end else begin
            tmr0_capcmp_pin     <= cap_sel & pin_sync;
            tmr0_capcmp_pin_sel <= cap_sel;
            ext_timer_clock_a   <= clk_a_en & pin_sync[2];
            ext_timer_clock_b   <= clk_b_en & pin_sync[3];
        end
    end

    // ==========================================================
    // Port view: data bit for outputs, pin level for inputs
    // Timer-owned pins still read via direction
    assign pin_state = (dir_q & data_q) | (~dir_q & pin_sync);

    // ==========================================================
    // APB handshake: one wait cycle while read data is loaded
    // Unmapped addresses get an error, no hang
    // Writes need a mapped, completing access
    assign addr_ok = (paddr == `PMX_OFS_MODE)     || (paddr == `PMX_OFS_IOCTL_HI) ||
                     (paddr == `PMX_OFS_IOCTL_LO) || (paddr == `PMX_OFS_CTRL0)    ||
                     (paddr == `PMX_OFS_PSC12)    || (paddr == `PMX_OFS_DIR)      ||
                     (paddr == `PMX_OFS_DATA)     || (paddr == `PMX_OFS_PINS)     ||
                     (paddr == `PMX_OFS_FNSTAT);
    assign pready  = psel & penable & ack_q;
    assign pslverr = pready & ~addr_ok;
    assign wr_en   = pready & pwrite & addr_ok;

    // Ack goes high after the first access cycle, low on completion
    // Clearing on completion allows back to back
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ack_q <= 1'b0;
        end else if (pready) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= psel & penable;
        end
    end

    // ==========================================================
    // Read multiplexer
    // Unused upper bits read as zero
    always @* begin
        rd_d = 32'h0000_0000;
        case (paddr)
            `PMX_OFS_MODE:     rd_d[5:0] = timer0_mode_register_q;
            `PMX_OFS_IOCTL_HI: rd_d[7:0] = timer0_io_control_high_q;
            `PMX_OFS_IOCTL_LO: rd_d[7:0] = timer0_io_control_low_q;
            `PMX_OFS_CTRL0:    rd_d[7:0] = timer0_control_register_q;
            `PMX_OFS_PSC12:    rd_d[6:0] = psc12_q;
            `PMX_OFS_DIR:      rd_d[3:0] = dir_q;
            `PMX_OFS_DATA:     rd_d[3:0] = data_q;
            `PMX_OFS_PINS:     rd_d[3:0] = pin_state;
            `PMX_OFS_FNSTAT: begin
                rd_d[3:0]                               = tmr_sel;
                rd_d[`PMX_FN_CAP_LSB+3:`PMX_FN_CAP_LSB] = cap_sel;
                rd_d[`PMX_FN_ECA_BIT]                   = clk_a_en;
                rd_d[`PMX_FN_ECB_BIT]                   = clk_b_en;
            end
            default:           rd_d = 32'h0000_0000;
        endcase
    end

    // Read data loads in the first access cycle of a read
    // Loaded once, steady while pready is high
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel & penable & ~pwrite & ~ack_q) begin
            prdata <= rd_d;
        end
    end

    // ==========================================================
    // Register writes, taken at the completing edge only
    // Bits above a register's width are dropped
    // Unmapped writes change nothing
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer0_mode_register_q    <= 6'h00;
            timer0_io_control_high_q  <= `PMX_RST_8;
            timer0_io_control_low_q   <= `PMX_RST_8;
            timer0_control_register_q <= `PMX_RST_8;
            psc12_q                   <= 7'h00;
            dir_q                     <= `PMX_RST_4;
            data_q                    <= `PMX_RST_4;
        end else if (wr_en) begin
            case (paddr)
                `PMX_OFS_MODE:     timer0_mode_register_q    <= pwdata[5:0];
                `PMX_OFS_IOCTL_HI: timer0_io_control_high_q  <= pwdata[7:0];
                `PMX_OFS_IOCTL_LO: timer0_io_control_low_q   <= pwdata[7:0];
                `PMX_OFS_CTRL0:    timer0_control_register_q <= pwdata[7:0];
                `PMX_OFS_PSC12:    psc12_q                   <= pwdata[6:0];
                `PMX_OFS_DIR:      dir_q                     <= pwdata[3:0];
                `PMX_OFS_DATA:     data_q                    <= pwdata[3:0];
                default: begin
                    // Read-only and status offsets ignore writes
                end
            endcase
        end
    end

endmodule // pmx_port1_low

/* hdl/pmx_consts.vh */
// Constants for the port 1 low-pin timer function selector.
// Assumes inclusion by the design files of this block only.
`ifndef PMX_CONSTS_VH
`define PMX_CONSTS_VH

// ==========================================================
// Register byte offsets on the APB
`define PMX_OFS_MODE      8'h00
`define PMX_OFS_IOCTL_HI  8'h04
`define PMX_OFS_IOCTL_LO  8'h08
`define PMX_OFS_CTRL0     8'h0c
`define PMX_OFS_PSC12     8'h10
`define PMX_OFS_DIR       8'h14
`define PMX_OFS_DATA      8'h18
`define PMX_OFS_PINS      8'h1c
`define PMX_OFS_FNSTAT    8'h20

// ==========================================================
// Field positions
`define PMX_MODE_BFA_BIT   4
`define PMX_MODE_BFB_BIT   5
`define PMX_CTRL_CCLR_LSB  5
`define PMX_PSC12_CH2_LSB  3
`define PMX_PSC12_PHC_BIT  6
`define PMX_FN_CAP_LSB     4
`define PMX_FN_ECA_BIT     8
`define PMX_FN_ECB_BIT     9

// ==========================================================
// Reset values
`define PMX_RST_4          4'h0
`define PMX_RST_8          8'h00

// ==========================================================
// Timer mode and field codes
`define PMX_MODE_NORMAL    4'h0
`define PMX_MODE_PWM1      4'h2
`define PMX_MODE_PWM2      4'h3
`define PMX_IOC_CAPTURE    2'h2
`define PMX_IOC_NOOUT      2'h0
`define PMX_CCLR_PIN0      3'h1
`define PMX_CCLR_PIN1      3'h2
`define PMX_CCLR_PIN2      3'h5
`define PMX_CCLR_PIN3      3'h6
`define PMX_PSC_EXT_A      3'h4
`define PMX_PSC_EXT_B      3'h5

`endif

/* hdl/pmx_sync3.v */
// Three-stage synchroniser with agreement filter for pin levels.
// Assumes asynchronous inputs and a single pclk domain.
`timescale 1ns/1ps

module pmx_sync3 #(
    parameter WIDTH = 4                       // Number of pins
) (
    input  wire             pclk,             // System clock
    input  wire             presetn,          // Async reset, active low
    input  wire [WIDTH-1:0] async_in,         // Raw pin levels
    output reg  [WIDTH-1:0] level_q           // Filtered level
);

    reg [WIDTH-1:0] s1_q;                     // First stage, read by s2 only
    reg [WIDTH-1:0] s2_q;                     // Second stage
    reg [WIDTH-1:0] s3_q;                     // Third stage
    integer         i;                        // Bit index

    // ==========================================================
    // Shift chain; a change counts once stages two and three agree
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q    <= {WIDTH{1'b0}};
            s2_q    <= {WIDTH{1'b0}};
            s3_q    <= {WIDTH{1'b0}};
            level_q <= {WIDTH{1'b0}};
        end else begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            for (i = 0; i < WIDTH; i = i + 1) begin
                // Keep old level while stages disagree
                if (s2_q[i] == s3_q[i]) begin
                    level_q[i] <= s3_q[i];
                end
            end
        end
    end

endmodule // pmx_sync3

/* hdl/pmx_pin_fn.v */
// Per-pin decode of the timer channel 0 settings into pin functions.
// Assumes stable register fields from the same clock domain.
`timescale 1ns/1ps
`include "pmx_consts.vh"

module pmx_pin_fn #(
    parameter       PWM1_OK    = 1'b0,        // Pin may carry PWM mode 1 output
    parameter       BUF_GATE   = 1'b0,        // Buffer modes suppress output
    parameter [2:0] CCLR_BLOCK = 3'h0         // Clear source blocking PWM mode 2
) (
    input  wire [3:0] mode,                   // Timer mode field
    input  wire [3:0] ioc,                    // This pin's I/O control field
    input  wire [2:0] cclr,                   // Counter clear select
    input  wire       buf_on,                 // Either buffer mode set
    output wire       tmr_out_sel,            // Timer drives the pin
    output wire       cap_sel                 // Pin is capture source
);

    wire ioc_drives;                          // Control is not xx00
    wire cmp_sel;                             // Compare output selected
    wire pwm1_sel;                            // PWM mode 1 selected
    wire pwm2_sel;                            // PWM mode 2 selected

    // ==========================================================
    // Output function decode
    assign ioc_drives = (ioc[1:0] != `PMX_IOC_NOOUT);
    // Codes 0001-0011 and 0101-0111 drive compare output
    assign cmp_sel    = (mode == `PMX_MODE_NORMAL) && !ioc[3] && ioc_drives;
    assign pwm1_sel   = PWM1_OK && (mode == `PMX_MODE_PWM1) && ioc_drives;
    assign pwm2_sel   = (mode == `PMX_MODE_PWM2) && ioc_drives && (cclr != CCLR_BLOCK);
    // Buffer operation returns the pin to general use
    assign tmr_out_sel = (cmp_sel || pwm1_sel || pwm2_sel) && !(BUF_GATE && buf_on);

    // ==========================================================
    // Capture source decode, code 10xx in normal mode
    assign cap_sel = (mode == `PMX_MODE_NORMAL) && (ioc[3:2] == `PMX_IOC_CAPTURE);

endmodule // pmx_pin_fn

/* verif/pmx_port1_low_chk.sv */
// Concurrent checks on the port 1 low-pin function selector ports.
// Assumes binding to pmx_port1_low and a single pclk domain.
`timescale 1ns/1ps

module pmx_port1_low_chk (
    input logic        pclk,                 // System clock
    input logic        presetn,              // Async reset, active low
    input logic        psel,                 // APB select
    input logic        penable,              // APB access phase
    input logic        pwrite,               // APB write
    input logic [7:0]  paddr,                // APB byte address
    input logic        pready,               // APB ready
    input logic        pslverr,              // APB error
    input logic [3:0]  tmr0_capcmp_out,      // Timer output levels
    input logic [3:0]  pin_in,               // Pin levels
    input logic [3:0]  pin_out,              // Pin drive levels
    input logic [3:0]  pin_oe,               // Pin output enables
    input logic [3:0]  tmr0_capcmp_pin,      // Capture levels
    input logic        ext_timer_clock_a,    // External clock A
    input logic        ext_timer_clock_b     // External clock B
);
    // ==========================================================
    // Clocking, reset and shared sequences
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic wr_done;                           // Write completes this edge, mapped or not
    assign wr_done = psel & penable & pready & pwrite;
    sequence s_acc_start;
        psel && penable && !$past(penable);
    endsequence
    sequence s_low6(x);
        !x [*6];
    endsequence

    // ==========================================================
    // Bus handshake
    a_one_wait: assert property (s_acc_start |-> !pready ##1 pready)
        else $error("pready not in second access cycle");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_ready_access: assert property (pready |-> psel && penable)
        else $error("pready outside access phase");
    a_err_decode: assert property (pready |-> pslverr == (paddr > 8'h20 || paddr[1:0] != 2'h0))
        else $error("pslverr does not match address decode");

    // ==========================================================
    // Pin drive and sampled inputs
    a_oe_reset: assert property ($rose(presetn) |-> pin_oe == 4'h0)
        else $error("pins not inputs after reset");
    a_oe_after_write: assert property ($changed(pin_oe) |-> $past(wr_done, 2))
        else $error("pin_oe changed without a register write");
    a_out_follows: assert property ($changed(pin_out) && !$past(wr_done, 2) |->
        $past(tmr0_capcmp_out) != $past(tmr0_capcmp_out, 2))
        else $error("pin_out changed without cause");
    a_clk_a_low: assert property (s_low6(pin_in[2]) |=> !ext_timer_clock_a)
        else $error("clock A high while pin 2 low");
    a_clk_b_low: assert property (s_low6(pin_in[3]) |=> !ext_timer_clock_b)
        else $error("clock B high while pin 3 low");
    a_cap_a_low: assert property (s_low6(pin_in[0]) |=> !tmr0_capcmp_pin[0])
        else $error("capture A high while pin 0 low");
endmodule // pmx_port1_low_chk

bind pmx_port1_low pmx_port1_low_chk u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pready(pready), .pslverr(pslverr), .tmr0_capcmp_out(tmr0_capcmp_out),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .tmr0_capcmp_pin(tmr0_capcmp_pin),
    .ext_timer_clock_a(ext_timer_clock_a), .ext_timer_clock_b(ext_timer_clock_b));

/* verif/pmx_pin_partner.sv */
// Outside circuitry on the four shared port pins.
// Assumes the bench chooses the level it forces on undriven pins.
`timescale 1ns/1ps

module pmx_pin_partner (
    input  logic [3:0] pin_out,              // Device drive level
    input  logic [3:0] pin_oe,               // Device drive enable
    input  logic [3:0] ext_drive,            // Level forced from outside
    output logic [3:0] pin_in                // Resolved pin level
);
    // ==========================================================
    // Wire resolution: the device wins where it drives, else outside level
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_drive);
endmodule // pmx_pin_partner

/* verif/pmx_port1_low_tb_top.sv */
// Self-checking bench for the port 1 low-pin function selector.
// Assumes the checker is bound and the partner resolves the pins.
`timescale 1ns/1ps

module pmx_port1_low_tb_top;
    // ==========================================================
    // Signals and scoreboard
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;              // Bus address
    logic [31:0] pwdata = 32'h0, prdata, w;  // Bus data, scratch word
    logic [3:0]  tmr = 4'h0, ext = 4'h0;     // Timer levels, outside levels
    logic [3:0]  pin_in, pin_out, pin_oe, cap, sel, own, oe, out, lvl;
    logic        pready, pslverr, clka, clkb, snap = 1'b0;
    logic [9:0]  f;                          // Expected function status
    logic [32:0] rd_q[$];                    // Expected {error, read data}
    logic [17:0] pn_q[$];                    // Expected pin snapshot
    logic [7:0]  ra [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18};
    logic [7:0]  rm [7] = '{8'h3f, 8'hff, 8'hff, 8'hff, 8'h7f, 8'h0f, 8'h0f};
    logic [7:0]  v [7];                      // Register contents written
    int          fails = 0, checks = 0, i, k;

    always #5 pclk = ~pclk;

    pmx_port1_low dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
        .prdata(prdata), .tmr0_capcmp_out(tmr), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .tmr0_capcmp_pin(cap), .tmr0_capcmp_pin_sel(sel),
        .ext_timer_clock_a(clka), .ext_timer_clock_b(clkb));
    pmx_pin_partner u_pins (.pin_out(pin_out), .pin_oe(pin_oe), .ext_drive(ext), .pin_in(pin_in));

    // ==========================================================
    // Reporting and comparison
    task automatic end_sim;
        if (fails == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic cmp_rd(input logic [32:0] g, input logic [32:0] e);
        checks++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %0t read got %h exp %h", $time, g, e);
        end
    endtask
    task automatic cmp_pin(input logic [17:0] g, input logic [17:0] e);
        checks++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %0t pins got %h exp %h", $time, g, e);
        end
    endtask

    // Monitor: pops the oldest note whenever a result appears
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite && rd_q.size() > 0)
            cmp_rd({pslverr, prdata}, rd_q.pop_front());
        if (snap && pn_q.size() > 0)
            cmp_pin({clkb, clka, sel, cap, pin_oe, pin_out & pin_oe}, pn_q.pop_front());
    end

    // ==========================================================
    // Drivers and reference decode
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
        int n;
        n = 0;
        if (!wr) rd_q.push_back(e);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            fails++;
            end_sim;
        end
    endtask
    task automatic idle(input int n);
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (n) @(posedge pclk);
    endtask
    task automatic snap_pins(input logic [17:0] e);
        pn_q.push_back(e);
        snap <= 1'b1;
        @(posedge pclk);
        snap <= 1'b0;
    endtask
    function automatic logic [9:0] fexp(input logic [3:0] md, input logic [1:0] bf, input logic [15:0] io,
                                        input logic [2:0] cc, input logic [8:0] ps, input logic ph);
        logic [9:0] r;
        logic [3:0] c;
        logic [2:0] blk;
        r = 10'h0;
        for (int p = 0; p < 4; p++) begin
            c = io[4*p +: 4];
            blk = (p == 0) ? 3'h1 : (p == 1) ? 3'h2 : (p == 2) ? 3'h5 : 3'h6;
            r[p] = (c[1:0] != 2'h0) && ((md == 4'h0 && !c[3]) || (md == 4'h2 && !p[0]) ||
                   (md == 4'h3 && cc != blk));
            r[4+p] = (md == 4'h0) && (c[3:2] == 2'h2);
        end
        if (bf != 2'h0) r[2] = 1'b0;
        r[8] = ph || ps[2:0] == 3'h4 || ps[5:3] == 3'h4 || ps[8:6] == 3'h4;
        r[9] = ph || ps[2:0] == 3'h5 || ps[5:3] == 3'h5 || ps[8:6] == 3'h5;
        return r;
    endfunction

    // ==========================================================
    // Main sequence
    initial begin
        w = $urandom(32);
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (k = 0; k < 9; k++) apb(1'b0, 8'(k * 4), 32'h0, 33'h0);
        for (i = 0; i < 64; i++) begin
            for (k = 0; k < 7; k++) begin
                w = $urandom;
                if (k == 0) w[3:0] = (i % 4 == 1) ? 4'h2 : (i % 4 == 2) ? 4'h3 : (i % 4 == 3) ? w[3:0] : 4'h0;
                v[k] = w[7:0] & rm[k];
                apb(1'b1, ra[k], w, 33'h0);
                apb(1'b0, ra[k], 32'h0, {25'h0, v[k]});
            end
            tmr <= 4'($urandom);
            ext <= 4'($urandom);
            idle(8);
            f = fexp(v[0][3:0], v[0][5:4], {v[2], v[1]}, v[3][7:5], {v[4][5:0], v[3][2:0]}, v[4][6]);
            own = f[3:0];
            oe = own | v[5][3:0];
            out = (own & tmr) | (~own & v[6][3:0]);
            lvl = (oe & out) | (~oe & ext);
            snap_pins({f[9] & lvl[3], f[8] & lvl[2], f[7:4], f[7:4] & lvl, oe, out & oe});
            apb(1'b0, 8'h20, 32'h0, {23'h0, f});
            apb(1'b0, 8'h1c, 32'h0, {28'h0, (v[5][3:0] & v[6][3:0]) | (~v[5][3:0] & lvl)});
        end
        // Read-only and unmapped places
        apb(1'b1, 8'h20, 32'hffffffff, 33'h0);
        apb(1'b0, 8'h20, 32'h0, {23'h0, f});
        apb(1'b0, 8'h24, 32'h0, {1'b1, 32'h0});
        apb(1'b0, 8'h02, 32'h0, {1'b1, 32'h0});
        idle(2);
        end_sim;
    end
endmodule // pmx_port1_low_tb_top
